// file: repeater_pkg.sv
/*
 Shared constants and types of the seven-port repeater core.
 Assumes a 50 MHz core clock and a 10 Mb/s network bit rate.
*/
// Contract
// - seven identical per-port logic slices
// - port one always in external AUI mode
// - ports two to seven select transceiver type
// - each port partitions its faulty segment
// - per-port status register takes configuration writes
// - port logic picks receive or transmit
// - one shared 32-bit elasticity buffer
// - data muxed to decoder, activity to sequencer
// - transmit buffer data or 1010 pattern
// - timers enforce the six repeater intervals
// - decoder gives NRZ data, clock, enable
// - preamble sent early on other segments
// - buffer stores cascade stream after SFD
// - no readout before full preamble sent
// - buffered data Manchester encoded for transmit
// - cascade bus shares data and collisions
// - freeze LEDs 30 ms, strobe, end early
// - display cycle takes about 1.6 us
// - 4-bit data and address bus shared
// - arbiter schedules, display owns bus default
// - access enables buffer and sets direction
// - drive and sense source port activity
// - other-port activity on transmit or multi collision
package repeater_pkg;
	localparam int NPORTS = 7;
	localparam int CLK_NS = 20;
	localparam int BIT_NS = 100;
	localparam int BIT_CYC = BIT_NS / CLK_NS;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int DISP_NS = 1600;
	localparam int DISP_CYC = DISP_NS / CLK_NS;
	localparam int SLOT_CYC = DISP_CYC / NPORTS;
	localparam int SLOT_WR = SLOT_CYC / 2;
	localparam int FREEZE_MS = 30;
	localparam int FREEZE_CYC = FREEZE_MS * 1000000 / CLK_NS;
	localparam int EB_BITS = 32;
	localparam int PRE_BITS = 64;
	localparam int JAM_BITS = 96;
	localparam int COL_LIMIT = 31;
	localparam logic [7:0] LAST_PORT_OFS = 8'h18;
	localparam logic [7:0] CORE_OFS = 8'h20;
	localparam int F_DIS = 0;
	localparam int F_EXT = 1;
	localparam int F_SQL = 2;

	typedef enum logic [2:0] {S_IDLE, S_PRE, S_DATA, S_JAM, S_RECOV} core_state_t;

	typedef struct packed {
		logic [6:0] act;
		logic [6:0] col;
		logic [6:0] dat;
		logic source_port_activity;
		logic anyx;
		logic cd;
		logic ce;
		logic cc;
	} pins_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] data;
		logic data_oe;
		logic buf_en;
		logic buf_rd;
	} disp_bus_t;
endpackage

// file: multiport_repeater_core.sv
/*
 Seven-port repeater core: port slices, core sequencer, elasticity buffer,
 decoder/encoder, cascade bus, LED scheduler and APB register slave.
 Assumes pins are asynchronous to CORE_CLK_I and open-drain lines are
 resolved outside.
*/
`timescale 1ns/100ps
module multiport_repeater_core import repeater_pkg::*; #(
	parameter int TW1 = 96,
	parameter int TW2 = 96,
	parameter int TW3 = 50000,
	parameter int TW4 = 9600,
	parameter int TW5 = 2000,
	parameter int TW6 = 512,
	parameter int FREEZE = FREEZE_CYC
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Network ports
	input wire logic [6:0] RX_ACT_I,
	input wire logic [6:0] RX_COL_I,
	input wire logic [6:0] RX_DATA_I,
	output logic [6:0] TX_EN_O,
	output logic [6:0] TX_DATA_O,
	output logic [6:0] XCVR_EXT_O,
	output logic [6:0] SQUELCH_HI_O,
	// Open-drain activity lines
	input wire logic SOURCE_PORT_ACTIVITY_N_I,
	output logic SOURCE_PORT_ACTIVITY_N_O,
	output logic SOURCE_PORT_ACTIVITY_N_OE_O,
	input wire logic OTHER_PORT_ACTIVITY_N_I,
	output logic OTHER_PORT_ACTIVITY_N_O,
	output logic OTHER_PORT_ACTIVITY_N_OE_O,
	// Cascade bus
	input wire logic CASC_DATA_I,
	input wire logic CASC_EN_I,
	input wire logic CASC_CLK_I,
	output logic CASC_DATA_O,
	output logic CASC_EN_O,
	output logic CASC_CLK_O,
	output logic PKT_DRIVE_O,
	// Display bus
	output logic [3:0] DISP_ADDR_O,
	output logic [3:0] DISP_DATA_O,
	output logic DISP_DATA_OE_O,
	output logic BUF_EN_O,
	output logic BUF_READ_O,
	output logic DISPLAY_FROZEN_STROBE_N_O
);
	typedef struct packed {
		pins_t s1;
		pins_t s2;
		logic ccp;
		core_state_t cs;
		logic [2:0] portn;
		logic local_src;
		logic [3:0] bitc;
		logic [19:0] tmr;
		logic [19:0] jab;
		logic [6:0] pre;
		logic [EB_BITS-1:0] eb;
		logic [4:0] wp;
		logic [4:0] rp;
		logic [5:0] cnt;
		logic sfd;
		logic prevd;
		logic txbit;
		logic [6:0] txen;
		logic [6:0] txd;
		logic [6:0] dis;
		logic [6:0] ext;
		logic [6:0] sq;
		logic [6:0] part;
		logic [6:0] hadcol;
		logic [6:0] wasact;
		logic [6:0][4:0] ccnt;
		logic [6:0][15:0] len;
		logic dec_d;
		logic dec_c;
		logic dec_e;
		logic act_oe;
		logic anyx_oe;
		logic od_lvl;
		logic [6:0] slot;
		logic [20:0] fct;
		logic frozen;
		logic strobe_n;
		logic anyact;
		logic [6:0][3:0] snap;
		disp_bus_t bus;
		logic rdy;
		logic err;
		logic [31:0] rdata;
	} st_t;

	st_t q;
	st_t n;
	logic [6:0] ok;
	logic [6:0] col_ok;
	logic [6:0][3:0] led;
	logic [6:0][31:0] preg;
	logic tick, mid, sys_act, sys_col, any_rx, col_seen, txcol, wr, rd, act_now;
	logic port_hit, core_hit;
	logic [2:0] first, ncol, pi;
	logic [6:0] sub, pidx;
	logic [31:0] rd_word;

	for (genvar i = 0; i < NPORTS; i++) begin : g_port
		assign ok[i] = q.s2.act[i] & ~q.dis[i] & ~q.part[i];
		assign col_ok[i] = ok[i] & q.s2.col[i];
		assign led[i] = {q.part[i], col_ok[i], ok[i], q.txen[i]};
		assign preg[i] = {25'h0, q.txen[i], col_ok[i], ok[i], q.part[i], q.sq[i], q.ext[i], q.dis[i]};
	end

	always_comb begin
		n = q;
		n.s1 = {RX_ACT_I, RX_COL_I, RX_DATA_I, SOURCE_PORT_ACTIVITY_N_I, OTHER_PORT_ACTIVITY_N_I,
			CASC_DATA_I, CASC_EN_I, CASC_CLK_I};
		n.s2 = q.s1;
		n.ccp = q.s2.cc;
		tick = q.bitc == 4'(BIT_CYC - 1);
		mid = q.bitc == 4'(HALF_CYC);
		n.bitc = tick ? 4'h0 : q.bitc + 4'h1;
		sys_act = ~q.s2.source_port_activity;
		sys_col = ~q.s2.anyx;
		any_rx = |ok;
		first = 3'h0;
		ncol = 3'h0;
		for (int i = NPORTS - 1; i >= 0; i--) begin
			if (ok[i])
				first = 3'(i);
			ncol = ncol + {2'h0, col_ok[i]};
		end
		txcol = |(col_ok & q.txen);
		col_seen = (|col_ok) | sys_col;
		act_now = any_rx | sys_act;
		// Active segment's activity drives the source line; transmit or multiple collisions drive the other line
		n.act_oe = any_rx;
		n.anyx_oe = txcol | (ncol > 3'h1);
		// Cascade stream into the buffer, stored only after the delimiter
		wr = q.s2.ce & q.s2.cc & ~q.ccp & (q.cs == S_PRE || q.cs == S_DATA);
		rd = tick & (q.cs == S_DATA) & (q.cnt != 6'h0);
		if (wr) begin
			n.prevd = q.s2.cd;
			if (!q.sfd) begin
				n.sfd = q.prevd & q.s2.cd;
			end else begin
				n.eb[q.wp] = q.s2.cd;
				n.wp = q.wp + 5'h1;
			end
		end
		if (rd)
			n.rp = q.rp + 5'h1;
		n.cnt = q.cnt + {5'h0, wr & q.sfd} - {5'h0, rd};
		unique case (q.cs)
			S_IDLE: begin
				if (act_now) begin
					n.cs = S_PRE;
					n.portn = first;
					n.local_src = any_rx;
					// Entry bit is the first preamble bit, counted here
					n.pre = 7'h1;
					// Stale delimiter history would fake an early SFD
					n.prevd = 1'b0;
					n.jab = 20'h0;
					n.wp = 5'h0;
					n.rp = 5'h0;
					n.cnt = 6'h0;
					n.sfd = 1'b0;
				end
			end
			S_PRE, S_DATA: begin
				if (col_seen) begin
					n.cs = S_JAM;
					n.tmr = 20'(JAM_BITS - 1);
				end else if (tick) begin
					n.jab = q.jab + 20'h1;
					n.pre = q.pre + 7'h1;
					if (q.jab >= 20'(TW3)) begin
						n.cs = S_RECOV;
						n.tmr = 20'(TW4);
					end else if (q.cs == S_PRE && q.pre == 7'(PRE_BITS - 1)) begin
						n.cs = S_DATA;
					end else if (q.cs == S_DATA && q.cnt == 6'h0 && !act_now) begin
						n.cs = S_RECOV;
						n.tmr = 20'(TW1);
					end
				end
			end
			S_JAM: begin
				if (tick) begin
					if (q.tmr != 20'h0) begin
						n.tmr = q.tmr - 20'h1;
					end else if (!col_seen) begin
						n.cs = S_RECOV;
						n.tmr = 20'(TW2);
					end
				end
			end
			S_RECOV: begin
				if (tick) begin
					if (q.tmr == 20'h0)
						n.cs = S_IDLE;
					else
						n.tmr = q.tmr - 20'h1;
				end
			end
		endcase
		// Transmit bit: preamble ending in the delimiter, buffer data, or jam
		if (tick) begin
			if (q.cs == S_PRE)
				n.txbit = (q.pre >= 7'(PRE_BITS - 2)) | ~q.pre[0];
			else if (q.cs == S_DATA)
				n.txbit = (q.cnt != 6'h0) ? q.eb[q.rp] : 1'b1;
			else
				n.txbit = ~q.txbit;
		end
		// Restart the bit phase on entry, so no cut bit precedes the preamble
		if (q.cs == S_IDLE && n.cs == S_PRE) begin
			n.bitc = 4'h0;
			n.txbit = 1'b1;
		end
		for (int i = 0; i < NPORTS; i++) begin
			// Receiving segment is not echoed outside jam; partitioned ones still hear us
			n.txen[i] = ~q.dis[i] & ((n.cs == S_JAM) | ((n.cs == S_PRE || n.cs == S_DATA)
				& ~(n.local_src & (n.portn == 3'(i)))));
			n.txd[i] = n.txen[i] & ((n.bitc < 4'(HALF_CYC)) ? ~n.txbit : n.txbit);
			if (tick) begin
				n.wasact[i] = q.s2.act[i] & ~q.dis[i];
				if (q.s2.act[i] & ~q.dis[i]) begin
					if (q.len[i] != 16'hffff)
						n.len[i] = q.len[i] + 16'h1;
					if (q.s2.col[i])
						n.hadcol[i] = 1'b1;
					if (q.s2.col[i] && q.len[i] >= 16'(TW5))
						n.part[i] = 1'b1;
				end else if (q.wasact[i]) begin
					n.len[i] = 16'h0;
					n.hadcol[i] = 1'b0;
					if (q.hadcol[i]) begin
						n.ccnt[i] = q.ccnt[i] + 5'h1;
						if (q.ccnt[i] >= 5'(COL_LIMIT - 1))
							n.part[i] = 1'b1;
					end else if (q.len[i] >= 16'(TW6)) begin
						n.ccnt[i] = 5'h0;
						n.part[i] = 1'b0;
					end
				end
			end
		end
		// Decoder retimes the source port onto the cascade bus
		if (mid)
			n.dec_d = q.s2.dat[q.portn];
		if (mid)
			n.dec_c = 1'b0;
		else if (tick)
			n.dec_c = 1'b1;
		// Enable drops with the carrier, so the loopback stops filling the buffer
		n.dec_e = n.local_src & any_rx & (n.cs == S_PRE || n.cs == S_DATA || n.cs == S_JAM);
		// Display scheduler and freeze
		n.slot = (q.slot == 7'(DISP_CYC - 1)) ? 7'h0 : q.slot + 7'h1;
		sub = q.slot % 7'(SLOT_CYC);
		pidx = q.slot / 7'(SLOT_CYC);
		n.anyact = act_now;
		n.strobe_n = 1'b1;
		if (act_now) begin
			n.frozen = 1'b0;
			n.snap = led;
		end else if (q.anyact) begin
			n.frozen = 1'b1;
			n.strobe_n = 1'b0;
			n.fct = 21'(FREEZE - 1);
		end else if (q.frozen) begin
			if (q.fct == 21'h0)
				n.frozen = 1'b0;
			else
				n.fct = q.fct - 21'h1;
		end
		// Device owns the bus unless a register access is granted
		n.bus.data_oe = 1'b1;
		n.bus.buf_en = 1'b0;
		n.bus.buf_rd = 1'b0;
		pi = pidx[2:0];
		if (pidx < 7'(NPORTS) && sub == 7'(SLOT_WR)) begin
			n.bus.addr = {1'b0, pi};
			n.bus.data = q.frozen ? q.snap[pi] : led[pi];
		end
		port_hit = PADDR_I <= LAST_PORT_OFS && PADDR_I[1:0] == 2'h0;
		core_hit = PADDR_I == CORE_OFS;
		rd_word = 32'h0;
		if (port_hit)
			rd_word = preg[PADDR_I[4:2]];
		else if (core_hit)
			rd_word = {18'h0, q.frozen, q.part, q.portn, q.cs};
		n.rdy = 1'b0;
		n.err = 1'b0;
		// Grant only at a slot boundary, never over a display write
		if (PSEL_I && PENABLE_I && !q.rdy && sub == 7'h0) begin
			n.rdy = 1'b1;
			n.err = ~(port_hit | core_hit);
			n.rdata = rd_word;
			n.bus.addr = PADDR_I[5:2];
			n.bus.buf_en = 1'b1;
			n.bus.buf_rd = ~PWRITE_I;
			n.bus.data_oe = ~PWRITE_I;
			n.bus.data = rd_word[3:0];
		end
		if (q.rdy && PSEL_I && PENABLE_I && PWRITE_I && port_hit) begin
			n.dis[PADDR_I[4:2]] = PWDATA_I[F_DIS];
			n.sq[PADDR_I[4:2]] = PWDATA_I[F_SQL];
			n.ext[PADDR_I[4:2]] = PWDATA_I[F_EXT] | (PADDR_I[4:2] == 3'h0);
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			q <= '0;
			q.s1.source_port_activity <= 1'b1;
			q.s1.anyx <= 1'b1;
			q.s2.source_port_activity <= 1'b1;
			q.s2.anyx <= 1'b1;
			q.ext <= 7'h01;
			q.strobe_n <= 1'b1;
			q.bus.data_oe <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign PRDATA_O = q.rdata;
	assign PREADY_O = q.rdy;
	assign PSLVERR_O = q.err;
	assign TX_EN_O = q.txen;
	assign TX_DATA_O = q.txd;
	assign XCVR_EXT_O = q.ext;
	assign SQUELCH_HI_O = q.sq;
	assign SOURCE_PORT_ACTIVITY_N_O = q.od_lvl;
	assign SOURCE_PORT_ACTIVITY_N_OE_O = q.act_oe;
	assign OTHER_PORT_ACTIVITY_N_O = q.od_lvl;
	assign OTHER_PORT_ACTIVITY_N_OE_O = q.anyx_oe;
	assign CASC_DATA_O = q.dec_d;
	assign CASC_EN_O = q.dec_e;
	assign CASC_CLK_O = q.dec_c;
	assign PKT_DRIVE_O = q.dec_e;
	assign DISP_ADDR_O = q.bus.addr;
	assign DISP_DATA_O = q.bus.data;
	assign DISP_DATA_OE_O = q.bus.data_oe;
	assign BUF_EN_O = q.bus.buf_en;
	assign BUF_READ_O = q.bus.buf_rd;
	assign DISPLAY_FROZEN_STROBE_N_O = q.strobe_n;

	localparam int ARB_WAIT = SLOT_CYC + 1;
	localparam int DISP_LEN = DISP_CYC;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence act_end_s;
		q.anyact ##1 !q.anyact;
	endsequence
	sequence strobe_s;
		(!q.strobe_n && q.frozen) ##1 q.strobe_n;
	endsequence

	port_one_aui_a: assert property (q.ext[0]) else $error("port one left external mode");
	src_no_echo_a: assert property (q.cs == S_DATA && q.local_src |-> !q.txen[q.portn])
		else $error("source port transmits");
	preamble_len_a: assert property (q.cs == S_DATA && $past(q.cs) == S_PRE |-> $past(q.pre) == 7'(PRE_BITS - 1))
		else $error("short preamble");
	eb_sfd_gate_a: assert property (q.wp != $past(q.wp) && $past(q.cs) != S_IDLE |-> $past(q.sfd))
		else $error("stored before delimiter");
	jam_min_a: assert property ($past(q.cs) == S_JAM && q.cs != S_JAM |-> $past(q.tmr) == 20'h0)
		else $error("jam cut short");
	strobe_pulse_a: assert property (act_end_s |-> strobe_s) else $error("no freeze strobe");
	freeze_break_a: assert property (q.frozen && (|ok || !q.s2.source_port_activity) |=> !q.frozen)
		else $error("freeze held over activity");
	apb_answer_a: assert property (PSEL_I && PENABLE_I && !q.rdy |-> ##[1:ARB_WAIT] q.rdy)
		else $error("access not granted");
	buf_dir_a: assert property (q.rdy |-> q.bus.buf_en && q.bus.buf_rd == !PWRITE_I && !q.bus.data_oe == PWRITE_I)
		else $error("buffer control wrong");
	disp_cycle_a: assert property (q.slot == 7'h0 |-> ##DISP_LEN q.slot == 7'h0)
		else $error("display cycle length");
endmodule // multiport_repeater_core

// file: repeater_peer.sv
/*
 Peer repeater on the cascade bus: sources one packet per go request.
 Assumes the bench resolves the shared activity line and cascade bus.
*/
`timescale 1ns/100ps
module repeater_peer (
	// Clock and request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [63:0] bits_i,
	input wire logic [6:0] nbits_i,
	// Cascade side
	output logic act_n_oe_o,
	output logic casc_data_o,
	output logic casc_en_o,
	output logic casc_clk_o,
	output logic busy_o
);
	int i;

	// Five cycles a bit, taken on the rising cascade clock
	task automatic send_bit(input logic b);
		casc_data_o <= b;
		casc_clk_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		casc_clk_o <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask

	initial begin
		act_n_oe_o = 1'b0;
		casc_data_o = 1'b0;
		casc_en_o = 1'b0;
		casc_clk_o = 1'b0;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i === 1'b1) begin
				busy_o <= 1'b1;
				act_n_oe_o <= 1'b1;
				// Late start keeps the stored backlog under 32 bits
				repeat (150) @(posedge clk_i);
				casc_en_o <= 1'b1;
				for (i = 0; i < 8; i++) send_bit(~i[0]);
				send_bit(1'b1);
				send_bit(1'b1);
				for (i = 0; i < int'(nbits_i); i++) send_bit(bits_i[i]);
				casc_en_o <= 1'b0;
				// Released line shows the inverse, clock stands low
				casc_data_o <= ~casc_data_o;
				casc_clk_o <= 1'b0;
				act_n_oe_o <= 1'b0;
				busy_o <= 1'b0;
			end
		end
	end
endmodule // repeater_peer

// file: multiport_repeater_core_bench.sv
/*
 Bench of the repeater core: register model over APB, peer packet, local packet.
 Assumes repeater_pkg and repeater_peer are compiled first.
*/
`timescale 1ns/100ps
module multiport_repeater_core_bench import repeater_pkg::*;;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic casc_d, casc_e, casc_c, pkt, buf_en, buf_rd, oe_dat, frz_n;
	logic src_oe, oth_oe, p_oe, p_d, p_e, p_c, p_busy, go, src_lvl, oth_lvl;
	logic [7:0] paddr;
	logic [3:0] d_addr, d_data;
	logic [31:0] pwdata, prdata, rd, wv;
	logic [6:0] rx_act, rx_col, rx_data, tx_en, tx_data, xcvr, sql, en_mask;
	logic [63:0] bits;
	logic [2:0] regm [7];
	logic q [$];
	logic got [$];
	int failures, samples_checked, i, n;
	logic [6:0] nb;

	multiport_repeater_core #(.TW1(8), .TW2(8), .TW3(200), .TW4(50), .TW5(40), .TW6(20), .FREEZE(200)) dut (
		.CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.RX_ACT_I(rx_act), .RX_COL_I(rx_col), .RX_DATA_I(rx_data), .TX_EN_O(tx_en), .TX_DATA_O(tx_data),
		.XCVR_EXT_O(xcvr), .SQUELCH_HI_O(sql), .SOURCE_PORT_ACTIVITY_N_I(~(src_oe | p_oe)),
		.SOURCE_PORT_ACTIVITY_N_O(src_lvl), .SOURCE_PORT_ACTIVITY_N_OE_O(src_oe), .OTHER_PORT_ACTIVITY_N_I(~oth_oe),
		.OTHER_PORT_ACTIVITY_N_O(oth_lvl), .OTHER_PORT_ACTIVITY_N_OE_O(oth_oe), .CASC_DATA_I(pkt ? casc_d : p_d),
		.CASC_EN_I(pkt ? casc_e : p_e), .CASC_CLK_I(pkt ? casc_c : p_c), .CASC_DATA_O(casc_d),
		.CASC_EN_O(casc_e), .CASC_CLK_O(casc_c), .PKT_DRIVE_O(pkt), .DISP_ADDR_O(d_addr), .DISP_DATA_O(d_data),
		.DISP_DATA_OE_O(oe_dat), .BUF_EN_O(buf_en), .BUF_READ_O(buf_rd), .DISPLAY_FROZEN_STROBE_N_O(frz_n));

	repeater_peer peer (.clk_i(clk), .go_i(go), .bits_i(bits), .nbits_i(nb), .act_n_oe_o(p_oe),
		.casc_data_o(p_d), .casc_en_o(p_e), .casc_clk_o(p_c), .busy_o(p_busy));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Idle cycle first, so no strobe is assigned twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1);
		// Grant waits at most one display slot, then one edge to show it
		chk("apb_latency", 32'h1, {31'h0, k <= SLOT_CYC + 1});
		chk("buf_enable", {30'h0, 1'b1, ~w}, {30'h0, buf_en, buf_rd});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Samples each transmitted bit in its second half
	task automatic capture(input int p);
		int w;
		got = {};
		w = 0;
		while (tx_en[p] !== 1'b1 && w < 2000) begin
			@(negedge clk);
			w++;
		end
		repeat (3) @(negedge clk);
		chk("tx_en_mask", {25'h0, en_mask}, {25'h0, tx_en});
		while (tx_en[p] === 1'b1) begin
			got.push_back(tx_data[p]);
			repeat (5) @(negedge clk);
		end
	endtask

	initial begin
		#(20 * 40000);
		failures++;
		stop_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_act, rx_col, rx_data, go, bits} = '0;
		rstn = 1'b0;
		void'($urandom(32'heb5c98d7));
		repeat (20) @(posedge clk);
		chk("reset_ext", 32'h1, {25'h0, xcvr});
		chk("reset_bus", 32'h3, {30'h0, oe_dat, frz_n});
		rstn <= 1'b1;
		for (i = 0; i < NPORTS; i++) begin
			wv = $urandom;
			apb(1'b1, 8'(4 * i), wv, rd, err);
			regm[i] = wv[2:0] | (i == 0 ? 3'b010 : 3'b000);
			apb(1'b0, 8'(4 * i), 32'h0, rd, err);
			chk("port_reg", {29'h0, regm[i]}, rd);
			chk("ext_select", {31'h0, regm[i][1]}, {31'h0, xcvr[i]});
			chk("squelch", {31'h0, regm[i][2]}, {31'h0, sql[i]});
		end
		apb(1'b0, 8'h24, 32'h0, rd, err);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
		for (i = 0; i < NPORTS; i++) apb(1'b1, 8'(4 * i), (i == 3) ? 32'h1 : 32'h0, rd, err);
		en_mask = 7'h77;
		nb = 7'(40 + $urandom % 25);
		bits = {$urandom, $urandom};
		q = {};
		for (i = 0; i < 62; i++) q.push_back(~i[0]);
		q.push_back(1'b1);
		q.push_back(1'b1);
		for (i = 0; i < nb; i++) q.push_back(bits[i]);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		capture(1);
		chk("bit_count", q.size(), got.size());
		for (i = 0; i < q.size() && i < got.size(); i++) chk("tx_bit", {31'h0, q[i]}, {31'h0, got[i]});
		repeat (200) @(posedge clk);
		rx_act <= 7'h04;
		repeat (40) begin
			@(posedge clk);
			rx_data <= 7'($urandom);
		end
		@(negedge clk);
		chk("local_tx_en", {25'h0, en_mask & ~7'h04}, {25'h0, tx_en});
		chk("src_drive", 32'h1, {31'h0, src_oe});
		chk("pkt_drive", 32'h1, {31'h0, pkt});
		// Wait for a fresh display write of port five's slot
		n = 0;
		while (d_addr === 4'h4 && n < 100) begin
			@(negedge clk);
			n++;
		end
		while (d_addr !== 4'h4 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk("disp_addr", 32'h4, {28'h0, d_addr});
		chk("disp_nibble", 32'h1, {28'h0, d_data});
		chk("drive_level", 32'h0, {30'h0, src_lvl, oth_lvl});
		@(posedge clk);
		rx_act <= 7'h00;
		n = 0;
		while (frz_n !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("freeze_strobe", 32'h0, {31'h0, frz_n});
		repeat (300) @(posedge clk);
		rx_act <= 7'h30;
		rx_col <= 7'h30;
		n = 0;
		while (oth_oe !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("multi_collision", 32'h1, {31'h0, oth_oe});
		@(posedge clk);
		rx_act <= 7'h00;
		rx_col <= 7'h00;
		repeat (300) @(posedge clk);
		stop_test();
	end
endmodule // multiport_repeater_core_bench
